/* File: inc/mem_block_pkg.sv */
// package for the internal memory block decoder
package mem_block_pkg;

    // ------------------------------------------------------------
    // block placement
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 32;
    localparam int          BASE_HI       = 31;
    localparam int          BASE_LO       = 22;
    localparam int          OFF_W         = 22;
    localparam logic [9:0]  BASE_LIMIT    = 10'h008;
    localparam logic [2:0]  BASE_SEL_RST  = 3'h0;

    // ------------------------------------------------------------
    // region offsets within the 4-Mbyte block
    // ------------------------------------------------------------
    localparam logic [21:0] FLASH_A_LO    = 22'h000000;
    localparam logic [21:0] FLASH_A_HI    = 22'h07FFFF;
    localparam logic [21:0] FLASH_B_LO    = 22'h080000;
    localparam logic [21:0] FLASH_B_HI    = 22'h0FFFFF;
    localparam logic [21:0] DECOMP_LO     = 22'h2F8000;
    localparam logic [21:0] DECOMP_HI     = 22'h2F8FFF;
    localparam logic [21:0] BBU_CTL_LO    = 22'h2FA000;
    localparam logic [21:0] BBU_CTL_HI    = 22'h2FBFFF;
    localparam logic [21:0] SIU_CTL_LO    = 22'h2FC000;
    localparam logic [21:0] SIU_CTL_HI    = 22'h2FFFFF;
    localparam logic [21:0] FLA_CTL_LO    = 22'h2FC800;
    localparam logic [21:0] FLA_CTL_HI    = 22'h2FC83F;
    localparam logic [21:0] FLB_CTL_LO    = 22'h2FC840;
    localparam logic [21:0] FLB_CTL_HI    = 22'h2FC87F;
    localparam logic [21:0] BRIDGE_LO     = 22'h300000;
    localparam logic [21:0] BRIDGE_HI     = 22'h307FFF;
    localparam logic [21:0] BRG_CTL_LO    = 22'h307F80;
    localparam logic [21:0] LBUS_CTL_LO   = 22'h380000;
    localparam logic [21:0] LBUS_CTL_HI   = 22'h3800FF;
    localparam logic [21:0] LBUS_RSV_LO   = 22'h384000;
    localparam logic [21:0] LBUS_RSV_HI   = 22'h3F6FFF;
    localparam logic [21:0] CAL_B_LO      = 22'h3F7000;
    localparam logic [21:0] CAL_B_HI      = 22'h3F7FFF;
    localparam logic [21:0] CAL_A_LO      = 22'h3F8000;
    localparam logic [21:0] CAL_A_HI      = 22'h3FFFFF;
    localparam logic [21:0] CAL_A_OVL_LO  = 22'h3FF000;

    // ------------------------------------------------------------
    // peripheral slots and protection
    // ------------------------------------------------------------
    localparam int          SLOT_NUM      = 32;
    localparam int          SLOT_LSB      = 10;
    localparam int          PROT_LSB      = 13;
    localparam int          PROT_BLOCKS   = 8;
    localparam logic [21:0] PROT_BASE     = 22'h3F0000;
    localparam int          SPR_CYCLES    = 2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        RGN_NONE     = 4'h0,
        RGN_FLASH_A  = 4'h1,
        RGN_FLASH_B  = 4'h2,
        RGN_DECOMP   = 4'h3,
        RGN_BBU_CTL  = 4'h4,
        RGN_SIU_CTL  = 4'h5,
        RGN_FLA_CTL  = 4'h6,
        RGN_FLB_CTL  = 4'h7,
        RGN_PERIPH   = 4'h8,
        RGN_BRG_CTL  = 4'h9,
        RGN_LBUS_CTL = 4'hA,
        RGN_CAL_A    = 4'hB,
        RGN_CAL_B    = 4'hC,
        RGN_RESERVED = 4'hD
    } region_t;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic                  from_core;
        logic                  overlay;
        logic [ADDR_W-1:0]     addr;
    } access_t;

    typedef struct packed {
        logic                  valid;
        logic                  hit;
        region_t               region;
        logic [4:0]            slot;
        logic [OFF_W-1:0]      offset;
    } route_t;

    typedef struct packed {
        logic                  dsi;
        logic                  mce;
        logic                  rsv_write;
    } fault_t;

endpackage : mem_block_pkg

/* File: rtl/region_decode.sv */
// combinational map from block offset to target region
`timescale 1ns/100ps
`default_nettype none
module region_decode (
    // offset in
    input  wire logic [21:0]           offset,
    // region out
    output mem_block_pkg::region_t     region,
    output logic [4:0]                 slot
);

    function automatic logic in_rng(input logic [21:0] a,
                                    input logic [21:0] lo,
                                    input logic [21:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // ------------------------------------------------------------
    // region priority: small windows before enclosing spaces
    // ------------------------------------------------------------
    always_comb begin
        region = mem_block_pkg::RGN_RESERVED;
        slot   = offset[mem_block_pkg::SLOT_LSB +: 5];
        if (in_rng(offset, mem_block_pkg::FLASH_A_LO,
                   mem_block_pkg::FLASH_A_HI)) begin
            region = mem_block_pkg::RGN_FLASH_A;
        end else if (in_rng(offset, mem_block_pkg::FLASH_B_LO,
                            mem_block_pkg::FLASH_B_HI)) begin
            region = mem_block_pkg::RGN_FLASH_B;
        end else if (in_rng(offset, mem_block_pkg::DECOMP_LO,
                            mem_block_pkg::DECOMP_HI)) begin
            region = mem_block_pkg::RGN_DECOMP;
        end else if (in_rng(offset, mem_block_pkg::BBU_CTL_LO,
                            mem_block_pkg::BBU_CTL_HI)) begin
            region = mem_block_pkg::RGN_BBU_CTL;
        end else if (in_rng(offset, mem_block_pkg::FLA_CTL_LO,
                            mem_block_pkg::FLA_CTL_HI)) begin
            region = mem_block_pkg::RGN_FLA_CTL;
        end else if (in_rng(offset, mem_block_pkg::FLB_CTL_LO,
                            mem_block_pkg::FLB_CTL_HI)) begin
            region = mem_block_pkg::RGN_FLB_CTL;
        end else if (in_rng(offset, mem_block_pkg::SIU_CTL_LO,
                            mem_block_pkg::SIU_CTL_HI)) begin
            region = mem_block_pkg::RGN_SIU_CTL;
        end else if (in_rng(offset, mem_block_pkg::BRG_CTL_LO,
                            mem_block_pkg::BRIDGE_HI)) begin
            region = mem_block_pkg::RGN_BRG_CTL;
        end else if (in_rng(offset, mem_block_pkg::BRIDGE_LO,
                            mem_block_pkg::BRIDGE_HI)) begin
            region = mem_block_pkg::RGN_PERIPH;
        end else if (in_rng(offset, mem_block_pkg::LBUS_CTL_LO,
                            mem_block_pkg::LBUS_CTL_HI)) begin
            region = mem_block_pkg::RGN_LBUS_CTL;
        end else if (in_rng(offset, mem_block_pkg::CAL_B_LO,
                            mem_block_pkg::CAL_B_HI)) begin
            region = mem_block_pkg::RGN_CAL_B;
        end else if (in_rng(offset, mem_block_pkg::CAL_A_LO,
                            mem_block_pkg::CAL_A_HI)) begin
            region = mem_block_pkg::RGN_CAL_A;
        end
    end

endmodule // region_decode
`default_nettype wire

/* File: rtl/spr_wait.sv */
// two-cycle access timer for burst buffer special-purpose registers
`timescale 1ns/100ps
`default_nettype none
module spr_wait (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // access
    input  wire logic start,
    output logic      done
);

    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic       done_q;
    logic       done_d;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (cnt_q != 2'h0) begin
            cnt_d = cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
                done_d = 1'b1;
            end
        end else if (start) begin
            cnt_d = 2'(mem_block_pkg::SPR_CYCLES - 1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 2'h0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;

endmodule // spr_wait
`default_nettype wire

/* File: rtl/mem_block_decoder.sv */
// internal memory block decoder: placement, routing and fault selection
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module mem_block_decoder (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // base configuration from the system interface unit
    input  wire logic                      base_wr,
    input  wire logic [2:0]                base_wdata,
    // protection configuration, one bit per 8-Kbyte block
    input  wire logic [7:0]                prot_mask,
    input  wire logic                      data_relocation_bit,
    // incoming access
    input  wire mem_block_pkg::access_t    acc,
    // special-purpose register access
    input  wire logic                      spr_req,
    // routed access
    output mem_block_pkg::route_t          route,
    output mem_block_pkg::fault_t          fault,
    output logic [2:0]                     base_sel,
    output logic                           overlay_ok,
    output logic                           spr_ack
);

    // ------------------------------------------------------------
    // base select register
    // ------------------------------------------------------------
    logic [2:0] base_q;
    logic [2:0] base_d;

    always_comb begin
        base_d = base_q;
        if (base_wr) begin
            base_d = base_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_q <= mem_block_pkg::BASE_SEL_RST;
        end else begin
            base_q <= base_d;
        end
    end

    // ------------------------------------------------------------
    // block hit and offset
    // ------------------------------------------------------------
    logic [9:0]  acc_hi;
    logic [21:0] acc_off;
    logic        blk_hit;

    always_comb begin
        acc_hi  = acc.addr[mem_block_pkg::BASE_HI:mem_block_pkg::BASE_LO];
        acc_off = acc.addr[mem_block_pkg::OFF_W-1:0];
        // upper bits can only name one of the first eight blocks
        blk_hit = (acc_hi < mem_block_pkg::BASE_LIMIT) &&
                  (acc_hi[2:0] == base_q);
    end

    mem_block_pkg::region_t rgn;
    logic [4:0]             rgn_slot;

    region_decode u_region_decode (
        .offset (acc_off),
        .region (rgn),
        .slot   (rgn_slot)
    );

    // ------------------------------------------------------------
    // calibration RAM protection and fault class
    // ------------------------------------------------------------
    function automatic logic is_cal(input mem_block_pkg::region_t r);
        is_cal = (r == mem_block_pkg::RGN_CAL_A) ||
                 (r == mem_block_pkg::RGN_CAL_B);
    endfunction

    logic [21:0] prot_rel;
    logic [2:0]  prot_idx;
    logic        cal_fault;
    logic        ovl_area;

    always_comb begin
        prot_rel  = acc_off - mem_block_pkg::PROT_BASE;
        prot_idx  = prot_rel[mem_block_pkg::PROT_LSB +: 3];
        cal_fault = blk_hit && acc.valid && is_cal(rgn) &&
                    prot_mask[prot_idx];
        ovl_area  = (rgn == mem_block_pkg::RGN_CAL_B) ||
                    ((rgn == mem_block_pkg::RGN_CAL_A) &&
                     (acc_off >= mem_block_pkg::CAL_A_OVL_LO));
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    mem_block_pkg::route_t route_q;
    mem_block_pkg::route_t route_d;
    mem_block_pkg::fault_t fault_q;
    mem_block_pkg::fault_t fault_d;
    logic                  ovl_q;
    logic                  ovl_d;

    always_comb begin
        route_d        = '0;
        route_d.valid  = acc.valid;
        route_d.hit    = acc.valid && blk_hit;
        route_d.region = blk_hit ? rgn : mem_block_pkg::RGN_NONE;
        route_d.slot   = rgn_slot;
        route_d.offset = acc_off;
        ovl_d          = acc.valid && blk_hit && ovl_area;
        fault_d        = '0;
        if (cal_fault) begin
            if (acc.from_core && !acc.overlay) begin
                fault_d.dsi = data_relocation_bit;
            end else begin
                fault_d.mce = 1'b1;
            end
        end
        // flag writes into reserved space for the system monitor
        fault_d.rsv_write = acc.valid && blk_hit && acc.write &&
                            (rgn == mem_block_pkg::RGN_RESERVED);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            route_q <= '0;
            fault_q <= '0;
            ovl_q   <= 1'b0;
        end else begin
            route_q <= route_d;
            fault_q <= fault_d;
            ovl_q   <= ovl_d;
        end
    end

    spr_wait u_spr_wait (
        .clk   (clk),
        .rst_n (rst_n),
        .start (spr_req),
        .done  (spr_ack)
    );

    assign route      = route_q;
    assign fault      = fault_q;
    assign base_sel   = base_q;
    assign overlay_ok = ovl_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_base_write;
        @(posedge clk) disable iff (!rst_n)
        base_wr |=> (base_sel == $past(base_wdata));
    endproperty
    a_base_write: assert property (p_base_write)
        else $error("base select not updated");

    property p_hit_base;
        @(posedge clk) disable iff (!rst_n)
        route.hit |-> ($past(acc.addr[31:25]) == 7'h00);
    endproperty
    a_hit_base: assert property (p_hit_base)
        else $error("hit above the eighth block");

    property p_flash;
        @(posedge clk) disable iff (!rst_n)
        (acc.valid && blk_hit && acc_off[21:20] == 2'h0) |=>
        (route.region == (route.offset[19] ?
            mem_block_pkg::RGN_FLASH_B : mem_block_pkg::RGN_FLASH_A));
    endproperty
    a_flash: assert property (p_flash)
        else $error("flash routing wrong");

    property p_decomp;
        @(posedge clk) disable iff (!rst_n)
        (route.hit && route.offset[21:12] == 10'h2F8) |->
        (route.region == mem_block_pkg::RGN_DECOMP);
    endproperty
    a_decomp: assert property (p_decomp)
        else $error("decompression ram not routed");

    property p_brg;
        @(posedge clk) disable iff (!rst_n)
        (route.hit && route.offset[21:7] == 15'h60FF) |->
        (route.region == mem_block_pkg::RGN_BRG_CTL);
    endproperty
    a_brg: assert property (p_brg)
        else $error("bridge control not routed");

    property p_lbus_rsv;
        @(posedge clk) disable iff (!rst_n)
        (route.hit && route.offset >= mem_block_pkg::LBUS_RSV_LO &&
         route.offset <= mem_block_pkg::LBUS_RSV_HI) |->
        (route.region == mem_block_pkg::RGN_RESERVED);
    endproperty
    a_lbus_rsv: assert property (p_lbus_rsv)
        else $error("reserved lbus range routed");

    property p_dsi;
        @(posedge clk) disable iff (!rst_n)
        fault.dsi |-> ($past(data_relocation_bit) && $past(acc.from_core)
                       && !$past(acc.overlay));
    endproperty
    a_dsi: assert property (p_dsi)
        else $error("data storage fault without cause");

    property p_excl;
        @(posedge clk) disable iff (!rst_n)
        !(fault.dsi && fault.mce);
    endproperty
    a_excl: assert property (p_excl)
        else $error("both faults raised");

    property p_spr;
        @(posedge clk) disable iff (!rst_n)
        ($rose(spr_req) && u_spr_wait.cnt_q == 2'h0) |-> ##2 spr_ack;
    endproperty
    a_spr: assert property (p_spr)
        else $error("spr access not two cycles");

    property p_siu;
        @(posedge clk) disable iff (!rst_n)
        (route.hit && route.offset[21:14] == 8'hBF &&
         route.offset[13:7] != 7'h10) |->
        (route.region ==
         mem_block_pkg::RGN_SIU_CTL);
    endproperty
    a_siu: assert property (p_siu)
        else $error("control space not routed");

    property p_bbu;
        @(posedge clk) disable iff (!rst_n)
        (route.hit &&
         route.offset[21:13] == 9'h17D) |->
        (route.region ==
         mem_block_pkg::RGN_BBU_CTL);
    endproperty
    a_bbu: assert property (p_bbu)
        else $error("buffer control not routed");

    property p_fl_ctl;
        @(posedge clk) disable iff (!rst_n)
        (route.hit &&
         route.offset[21:7] == 15'h5F90) |->
        (route.region == (route.offset[6] ?
            mem_block_pkg::RGN_FLB_CTL :
            mem_block_pkg::RGN_FLA_CTL));
    endproperty
    a_fl_ctl: assert property (p_fl_ctl)
        else $error("flash control not routed");

    property p_periph;
        @(posedge clk) disable iff (!rst_n)
        (route.hit && route.offset[21:15] == 7'h60 &&
         route.offset[14:7] != 8'hFF) |->
        (route.region == mem_block_pkg::RGN_PERIPH &&
         route.slot == route.offset[14:10]);
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral slot not routed");

    property p_lbus_ctl;
        @(posedge clk) disable iff (!rst_n)
        (route.hit &&
         route.offset[21:8] == 14'h3800) |->
        (route.region ==
         mem_block_pkg::RGN_LBUS_CTL);
    endproperty
    a_lbus_ctl: assert property (p_lbus_ctl)
        else $error("local control not routed");

    property p_cal_b;
        @(posedge clk) disable iff (!rst_n)
        (route.hit &&
         route.offset[21:12] == 10'h3F7) |->
        (route.region == mem_block_pkg::RGN_CAL_B &&
         overlay_ok);
    endproperty
    a_cal_b: assert property (p_cal_b)
        else $error("calibration ram b not routed");

    property p_cal_a;
        @(posedge clk) disable iff (!rst_n)
        (route.hit &&
         route.offset[21:15] == 7'h7F) |->
        (route.region == mem_block_pkg::RGN_CAL_A &&
         overlay_ok == (route.offset[14:12] == 3'h7));
    endproperty
    a_cal_a: assert property (p_cal_a)
        else $error("calibration ram a not routed");

    property p_miss;
        @(posedge clk) disable iff (!rst_n)
        (route.valid && !route.hit) |->
        (route.region == mem_block_pkg::RGN_NONE &&
         !overlay_ok && fault == '0);
    endproperty
    a_miss: assert property (p_miss)
        else $error("outside access routed");

    property p_mce;
        @(posedge clk) disable iff (!rst_n)
        fault.mce |->
        ($past(acc.valid) &&
         ($past(acc.overlay) || !$past(acc.from_core)));
    endproperty
    a_mce: assert property (p_mce)
        else $error("machine check without cause");

    property p_rsv;
        @(posedge clk) disable iff (!rst_n)
        fault.rsv_write |->
        (route.region == mem_block_pkg::RGN_RESERVED);
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved write flag wrong");

    property p_base_hold;
        @(posedge clk) disable iff (!rst_n)
        !base_wr |=> $stable(base_sel);
    endproperty
    a_base_hold: assert property (p_base_hold)
        else $error("base select moved");

    property p_spr_pulse;
        @(posedge clk) disable iff (!rst_n)
        spr_ack |=> !spr_ack;
    endproperty
    a_spr_pulse: assert property (p_spr_pulse)
        else $error("spr acknowledge held");

endmodule // mem_block_decoder
`default_nettype wire

/* File: dv/master_model.sv */
// bus master model that issues accesses into the decoder
`timescale 1ns/100ps
`default_nettype none
module master_model (
    // clock
    input  wire logic               clk,
    // deliberate misuse of reserved space
    input  wire logic               allow_rsv_wr,
    // access out
    output mem_block_pkg::access_t  acc
);
    initial acc = '0;

    // ------------------------------------------------------------
    // region map, used to keep writes out of reserved space
    // ------------------------------------------------------------
    function automatic mem_block_pkg::region_t region_of(logic [21:0] o);
        if (o <= 22'h07FFFF) return mem_block_pkg::RGN_FLASH_A;
        if (o <= 22'h0FFFFF) return mem_block_pkg::RGN_FLASH_B;
        if (o >= 22'h2F8000 && o <= 22'h2F8FFF) return mem_block_pkg::RGN_DECOMP;
        if (o >= 22'h2FA000 && o <= 22'h2FBFFF) return mem_block_pkg::RGN_BBU_CTL;
        if (o >= 22'h2FC800 && o <= 22'h2FC83F) return mem_block_pkg::RGN_FLA_CTL;
        if (o >= 22'h2FC840 && o <= 22'h2FC87F) return mem_block_pkg::RGN_FLB_CTL;
        if (o >= 22'h2FC000 && o <= 22'h2FFFFF) return mem_block_pkg::RGN_SIU_CTL;
        if (o >= 22'h307F80 && o <= 22'h307FFF) return mem_block_pkg::RGN_BRG_CTL;
        if (o >= 22'h300000 && o <= 22'h307F7F) return mem_block_pkg::RGN_PERIPH;
        if (o >= 22'h380000 && o <= 22'h3800FF) return mem_block_pkg::RGN_LBUS_CTL;
        if (o >= 22'h3F7000 && o <= 22'h3F7FFF) return mem_block_pkg::RGN_CAL_B;
        if (o >= 22'h3F8000) return mem_block_pkg::RGN_CAL_A;
        return mem_block_pkg::RGN_RESERVED;
    endfunction

    // one access per cycle; the access stays up until the next one
    task automatic access(input mem_block_pkg::access_t a);
        mem_block_pkg::access_t b;
        b = a;
        if (b.write && !allow_rsv_wr &&
            region_of(b.addr[21:0]) == mem_block_pkg::RGN_RESERVED)
            b.write = 1'b0;
        acc = b;
        @(posedge clk);
        #1;
    endtask
endmodule // master_model
`default_nettype wire

/* File: dv/internal_memory_block_decoder_tb_top.sv */
// self-checking bench for the internal memory block decoder
`timescale 1ns/100ps
`default_nettype none
module internal_memory_block_decoder_tb_top;
    logic                    clk;
    logic                    rst_n;
    logic                    base_wr;
    logic [2:0]              base_wd;
    logic [2:0]              base;
    logic [7:0]              mask;
    logic                    drb;
    logic                    spr_req;
    logic                    rsv_ok;
    mem_block_pkg::access_t  acc;
    mem_block_pkg::route_t   route;
    mem_block_pkg::fault_t   fault;
    logic [2:0]              base_sel;
    logic                    ovl_ok;
    logic                    spr_ack;
    int                      mismatches;
    int                      n_tests;
    logic [21:0] offs [35] = '{
        22'h000000, 22'h07FFFF, 22'h080000, 22'h0FFFFF, 22'h100000,
        22'h2F8000, 22'h2F8FFF, 22'h2F9000, 22'h2FA000, 22'h2FBFFF,
        22'h2FC000, 22'h2FC800, 22'h2FC83F, 22'h2FC840, 22'h2FC87F,
        22'h2FC880, 22'h2FFFFF, 22'h300000, 22'h300400, 22'h307C00,
        22'h307F7F, 22'h307F80, 22'h307FFF, 22'h308000, 22'h380000,
        22'h3800FF, 22'h380100, 22'h384000, 22'h3F6FFF, 22'h3F7000,
        22'h3F7FFF, 22'h3F8000, 22'h3FEFFF, 22'h3FF000, 22'h3FFFFF};

    always #5 clk = ~clk;

    master_model pm (.clk(clk), .allow_rsv_wr(rsv_ok), .acc(acc));

    mem_block_decoder uut (
        .clk(clk), .rst_n(rst_n), .base_wr(base_wr),
        .base_wdata(base_wd), .prot_mask(mask),
        .data_relocation_bit(drb), .acc(acc), .spr_req(spr_req),
        .route(route), .fault(fault), .base_sel(base_sel),
        .overlay_ok(ovl_ok), .spr_ack(spr_ack));

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic cmp(input string nm, input logic [39:0] e,
                       input logic [39:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    function automatic mem_block_pkg::access_t mk(logic [21:0] o,
                                                  logic w, c, v);
        return '{1'b1, w, c, v, {7'h0, base, o}};
    endfunction

    task automatic chk(input mem_block_pkg::access_t a);
        mem_block_pkg::region_t r;
        logic [21:0]            o;
        logic                   h;
        logic                   pf;
        pm.access(a);
        o = acc.addr[21:0];
        r = (acc.addr[31:22] === {7'h0, base}) ? pm.region_of(o) :
            mem_block_pkg::RGN_NONE;
        h = acc.valid && r != mem_block_pkg::RGN_NONE;
        pf = h && (r == mem_block_pkg::RGN_CAL_A ||
                   r == mem_block_pkg::RGN_CAL_B) && mask[o[15:13]];
        cmp("valid", acc.valid, route.valid);
        cmp("hit", h, route.hit);
        cmp("region", r, route.region);
        if (h) cmp("offset", o, route.offset);
        if (r == mem_block_pkg::RGN_PERIPH)
            cmp("slot", o[14:10], route.slot);
        cmp("dsi", pf && acc.from_core && !acc.overlay && drb,
            fault.dsi);
        cmp("mce", pf && (acc.overlay || !acc.from_core),
            fault.mce);
        cmp("rsv_write", h && r == mem_block_pkg::RGN_RESERVED &&
            acc.write, fault.rsv_write);
        cmp("overlay_ok", h && (r == mem_block_pkg::RGN_CAL_B ||
            (r == mem_block_pkg::RGN_CAL_A && o >= 22'h3FF000)),
            ovl_ok);
    endtask

    task automatic set_base(input logic [2:0] b);
        base_wr = 1'b1;
        base_wd = b;
        @(posedge clk);
        #1;
        base_wr = 1'b0;
        base = b;
        cmp("base_sel", b, base_sel);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        cmp("route_rst", 40'h0, route);
        cmp("fault_rst", 40'h0, fault);
        cmp("base_rst", 40'h0, base_sel);
        cmp("ovl_rst", 40'h0, ovl_ok);
        cmp("spr_rst", 40'h0, spr_ack);
    endtask

    task automatic t_map();
        for (int i = 0; i < 35; i++)
            chk(mk(offs[i], 1'b0, 1'b1, 1'b0));
    endtask

    task automatic t_base();
        for (int b = 0; b < 8; b++) begin
            set_base(b[2:0]);
            chk(mk(22'h2F8000, 1'b0, 1'b1, 1'b0));
            chk('{1'b1, 1'b0, 1'b1, 1'b0,
                  {7'h0, base + 3'h1, 22'h2F8000}});
        end
        chk('{1'b1, 1'b0, 1'b1, 1'b0, {10'h00F, 22'h2F8000}});
        chk('{1'b0, 1'b0, 1'b1, 1'b0, {7'h0, base, 22'h000000}});
        rst_n = 1'b0;
        #1;
        cmp("base_rerst", 40'h0, base_sel);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        base = 3'h0;
        set_base(3'h3);
    endtask

    task automatic t_fault();
        mask = 8'h08;
        for (int i = 0; i < 8; i++) begin
            drb = i[2];
            chk(mk(22'h3F7010, i[0], i[1], 1'b0));
            chk(mk(22'h3F7800, 1'b0, i[1], i[0]));
            chk(mk(22'h3F8000, 1'b0, i[1], i[0]));
        end
        mask = 8'h80;
        drb = 1'b1;
        chk(mk(22'h3FF000, 1'b1, 1'b1, 1'b1));
        chk(mk(22'h3FEFFF, 1'b0, 1'b1, 1'b0));
        chk(mk(22'h3FDFFF, 1'b0, 1'b1, 1'b0));
        mask = 8'h00;
        chk(mk(22'h3FF000, 1'b0, 1'b1, 1'b0));
    endtask

    task automatic t_rsv();
        chk(mk(22'h384000, 1'b1, 1'b1, 1'b0));
        rsv_ok = 1'b1;
        chk(mk(22'h384000, 1'b1, 1'b1, 1'b0));
        chk(mk(22'h100000, 1'b1, 1'b0, 1'b0));
        chk(mk(22'h2F9000, 1'b0, 1'b1, 1'b0));
        chk(mk(22'h300000, 1'b1, 1'b1, 1'b0));
        rsv_ok = 1'b0;
    endtask

    task automatic t_spr();
        logic [5:0] seen;
        spr_req = 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            #1;
            if (i == 1) spr_req = 1'b0;
            seen[i] = spr_ack;
        end
        cmp("spr_ack", 6'b000010, seen);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        base_wr = 1'b0;
        base_wd = 3'h0;
        base = 3'h0;
        mask = 8'h00;
        drb = 1'b0;
        spr_req = 1'b0;
        rsv_ok = 1'b0;
        mismatches = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        rst_n = 1'b1;
        t_map();
        t_base();
        t_fault();
        t_rsv();
        t_spr();
        stop_test();
    end
endmodule // internal_memory_block_decoder_tb_top
`default_nettype wire
